// *** logic/filter_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface filter_if;
  logic        raw;       // Unfiltered input level
  logic [31:0] limit;     // Cycles the level must persist
  logic        filtered;  // Qualified level
  modport ctrl (output raw, output limit, input filtered);
  modport filt (input raw, input limit, output filtered);
endinterface : filter_if
`default_nettype wire

// *** logic/motor_algo_fault_config_regs.sv ***
// Contract
// - Divider code 0..3 selects factor 1,2,4,8
// - Blank after PWM edge, code microseconds
// - Comparator deglitch equals code microseconds
// - Alignment duty cap from code table
// - Tuning two at 9C, resets 00200000
// - Fault one at 92 zero, two 94
// - Absent motor must persist code milliseconds; the logic maps the code through a table, 1 to 1000 ms
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module motor_algo_fault_config_regs #(
  // Cycles per millisecond; shorten in simulation
  parameter logic [31:0] MS_CYCLES = 32'(motor_cfg_pkg::CYC_PER_MS)
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // Commutation and fault inputs
  input  wire logic        pwm_edge,
  input  wire logic        comparator_raw,
  input  wire logic        absent_motor_raw,
  // Steering outputs
  output var  logic [3:0]  startup_rate_divider,
  output var  logic [6:0]  align_duty_limit,
  output var  logic        pwm_edge_blank_active,
  output wire logic        comparator_filtered,
  output wire logic        absent_motor_confirmed
);

  // Register slot lookup: bit 2 is hit, bits 1:0 the slot
  // The bus carries byte addresses while the map is kept as word
  // indices, so the low two bits must be zero for a hit
  // A misaligned access is treated like an unmapped one rather than
  // rounded down, so software cannot reach a register by accident
  // Used for both reads and writes so the two can never disagree
  function automatic logic [2:0] slot_of(input logic [31:0] addr);
    if (addr[1:0] != 2'h0) begin
      slot_of = 3'h0;
    end else if (addr[31:2] == motor_cfg_pkg::TUNE_ONE_IDX) begin
      slot_of = {1'b1, motor_cfg_pkg::SLOT_TUNE_ONE};
    end else if (addr[31:2] == motor_cfg_pkg::TUNE_TWO_IDX) begin
      slot_of = {1'b1, motor_cfg_pkg::SLOT_TUNE_TWO};
    end else if (addr[31:2] == motor_cfg_pkg::FAULT_ONE_IDX) begin
      slot_of = {1'b1, motor_cfg_pkg::SLOT_FAULT_ONE};
    end else if (addr[31:2] == motor_cfg_pkg::FAULT_TWO_IDX) begin
      slot_of = {1'b1, motor_cfg_pkg::SLOT_FAULT_TWO};
    end else begin
      // Unmapped locations read zero and drop writes
      slot_of = 3'h0;
    end
  endfunction : slot_of

  // Bus side state
  // Storage is one flop word per slot; reserved and parity bits are
  // kept exactly as written so a read returns what software stored
  // The pending write remembers only the slot, the data arrives in
  // the following cycle on hwdata
  logic [31:0] regs [motor_cfg_pkg::NUM_SLOTS];       // Register storage by slot
  logic [31:0] next_regs [motor_cfg_pkg::NUM_SLOTS];  // Next register storage
  logic        wr_pend;                                // Write data phase due
  logic        next_wr_pend;                           // Next write pending
  logic [1:0]  wr_slot;                                // Slot of pending write
  logic [1:0]  next_wr_slot;                           // Next pending slot
  logic [31:0] next_hrdata;                            // Next read data
  logic        next_hreadyout;                         // Next ready
  logic        next_hresp;                             // Next response
  logic        accept;                                 // Address phase taken
  logic [2:0]  lookup;                                 // Decoded address

  // Decoded steering values
  // Each field is turned into a ready-to-use count once per cycle
  // so the timers below compare against a flop, not a long decode
  // path; the cost is one cycle of lag after a register write
  // Cycle counts are 32 bits wide to hold the longest absent time
  logic [3:0]  next_divider;        // Next divide factor
  logic [6:0]  next_duty;           // Next duty cap
  logic [31:0] blank_cycles;        // Blanking length in cycles
  logic [31:0] next_blank_cycles;   // Next blanking length
  logic [31:0] filt_cycles;         // Comparator deglitch in cycles
  logic [31:0] next_filt_cycles;    // Next comparator deglitch
  logic [31:0] absent_cycles;       // Absent motor deglitch in cycles
  logic [31:0] next_absent_cycles;  // Next absent motor deglitch

  // Blanking timer
  // Counts down from the decoded length after each PWM edge
  // Zero means idle; the flag is derived from the next count so it
  // rises in the same cycle as the load
  logic [31:0] blank_count;         // Cycles of blanking left
  logic [31:0] next_blank_count;    // Next cycles left
  logic        next_blank_active;   // Next blanking flag

  // Filter channels
  // Both qualifiers share one filter module through an interface,
  // so a fix to the counting rule lands in both at once
  // The comparator path uses microsecond limits, the absent motor
  // path millisecond limits; only the limit value differs
  filter_if comp_chan ();
  filter_if absent_chan ();

  // An address phase counts only while the bus is ready
  // Bit 1 of htrans separates NONSEQ and SEQ from IDLE and BUSY
  // hsel is checked here so traffic to other slaves on the same
  // bus never disturbs this bank
  // Size is only checked for writes; any read returns a full word
  assign accept = hsel && hready && htrans[1];
  assign lookup = slot_of(haddr);

  // Bus next state: write data lands one cycle after its address phase
  // The address phase only records the target slot; the word is
  // taken from hwdata in the data phase that follows
  // Read data is loaded at the address edge so it stands for the
  // whole data phase, and drops back to zero afterwards
  // Zero outside a read keeps stale register contents off a shared
  // read mux
  // A read that follows a write to the same slot in the very next
  // cycle sees the new word through the forward path
  always_comb begin
    next_regs      = regs;
    next_wr_pend   = 1'b0;
    next_wr_slot   = wr_slot;
    next_hrdata    = 32'h00000000;
    // Zero wait states; every answer is OKAY
    next_hreadyout = 1'b1;
    next_hresp     = motor_cfg_pkg::HRESP_OKAY;
    if (wr_pend) begin
      // Whole word stored, reserved and parity bits included
      next_regs[wr_slot] = hwdata;
    end
    if (accept) begin
      if (hwrite) begin
        // Only whole-word writes to a listed slot are kept
        next_wr_pend = lookup[2] && (hsize == motor_cfg_pkg::HSIZE_WORD);
        next_wr_slot = lookup[1:0];
      end else if (lookup[2]) begin
        // Forward a write still in its data phase to the same slot
        if (wr_pend && (wr_slot == lookup[1:0])) begin
          next_hrdata = hwdata;
        end else begin
          next_hrdata = regs[lookup[1:0]];
        end
      end else begin
        // Unmapped read answers zero
        next_hrdata = 32'h00000000;
      end
    end
  end

  // Bus registers
  // Reset values come from the package so the bank and the software
  // view agree on them
  // Ready and response are flops too, held at ready and OKAY; the
  // bank never inserts a wait state or returns an error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      regs[motor_cfg_pkg::SLOT_TUNE_ONE]  <= motor_cfg_pkg::RST_TUNE_ONE;
      regs[motor_cfg_pkg::SLOT_TUNE_TWO]  <= motor_cfg_pkg::RST_TUNE_TWO;
      regs[motor_cfg_pkg::SLOT_FAULT_ONE] <= motor_cfg_pkg::RST_FAULT_ONE;
      regs[motor_cfg_pkg::SLOT_FAULT_TWO] <= motor_cfg_pkg::RST_FAULT_TWO;
      wr_pend   <= 1'b0;
      wr_slot   <= 2'h0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= motor_cfg_pkg::HRESP_OKAY;
    end else begin
      regs      <= next_regs;
      wr_pend   <= next_wr_pend;
      wr_slot   <= next_wr_slot;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= next_hresp;
    end
  end

  // Field decode; registered so every output leaves from a flop
  // The divider is a shift and the duty cap a table lookup; blank and comparator
  // times scale a microsecond code by the cycles per microsecond
  // The absent motor time goes through a millisecond table first
  // and is then scaled by MS_CYCLES, which simulation shortens
  // Products are cut to 32 bits on purpose; the largest value, a
  // full second of clock cycles, still fits
  always_comb begin
    next_divider = motor_cfg_pkg::divide_factor(
      regs[motor_cfg_pkg::SLOT_TUNE_ONE][motor_cfg_pkg::DIV_LSB +: motor_cfg_pkg::DIV_W]);
    next_duty = motor_cfg_pkg::align_duty_pct(
      regs[motor_cfg_pkg::SLOT_TUNE_TWO][motor_cfg_pkg::ALIGN_LSB +: motor_cfg_pkg::ALIGN_W]);
    // One microsecond per code step
    next_blank_cycles = 32'(
      regs[motor_cfg_pkg::SLOT_TUNE_TWO][motor_cfg_pkg::BLANK_LSB +: motor_cfg_pkg::BLANK_W]
      * motor_cfg_pkg::BLANK_STEP_CYC);
    next_filt_cycles = 32'(
      regs[motor_cfg_pkg::SLOT_TUNE_TWO][motor_cfg_pkg::FILT_LSB +: motor_cfg_pkg::FILT_W]
      * motor_cfg_pkg::FILT_STEP_CYC);
    // Milliseconds scaled by the per-millisecond count
    next_absent_cycles = 32'(32'(motor_cfg_pkg::absent_motor_ms(
      regs[motor_cfg_pkg::SLOT_FAULT_ONE][motor_cfg_pkg::ABSENT_LSB +: motor_cfg_pkg::ABSENT_W]))
      * MS_CYCLES);
  end

  // Decode registers; reset shows the decode of the reset values, except the absent limit, which reads zero
  // During reset the timer limits read zero, so a filter could
  // pass a level one cycle after release before the real limits
  // arrive; the first edge after release loads them
  // Outputs follow a register write one cycle after the data phase
  // Software needing the new value at once must allow for this lag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      startup_rate_divider <= motor_cfg_pkg::divide_factor(2'h0);
      align_duty_limit     <= motor_cfg_pkg::align_duty_pct(3'h0);
      blank_cycles         <= 32'h00000000;
      filt_cycles          <= 32'h00000000;
      absent_cycles        <= 32'h00000000;
    end else begin
      startup_rate_divider <= next_divider;
      align_duty_limit     <= next_duty;
      blank_cycles         <= next_blank_cycles;
      filt_cycles          <= next_filt_cycles;
      absent_cycles        <= next_absent_cycles;
    end
  end

  // The window length is the decoded code times one microsecond
  // A code written while a window runs takes effect at the next
  // edge; the running window keeps its old length
  // pwm_edge is expected as a one-cycle pulse; a held level keeps
  // reloading the counter and so keeps the window open
  // Blanking: each PWM edge restarts the window, so close edges
  // extend it rather than cut it short
  always_comb begin
    next_blank_count = blank_count;
    if (pwm_edge) begin
      next_blank_count = blank_cycles;
    end else if (blank_count != 32'h00000000) begin
      next_blank_count = blank_count - 32'h00000001;
    end
    // A zero code never raises the flag
    next_blank_active = (next_blank_count != 32'h00000000);
  end

  // Blanking registers
  // Count and flag are registered together so the flag can never
  // disagree with the count seen by other logic
  // Both clear at reset, so no window is open after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blank_count           <= 32'h00000000;
      pwm_edge_blank_active <= 1'b0;
    end else begin
      blank_count           <= next_blank_count;
      pwm_edge_blank_active <= next_blank_active;
    end
  end

  // Comparator deglitch channel
  // The comparator is taken as already synchronous to hclk; an
  // asynchronous source would need a synchroniser ahead of this
  // A limit of zero lets a change through on the next edge
  assign comp_chan.raw   = comparator_raw;
  assign comp_chan.limit = filt_cycles;

  // Absent motor raw is high while no motor is sensed
  // The limit may reach a full second, so the count is 32 bits
  // Absent motor qualification channel; a long persistence keeps
  // a stalled but present rotor from tripping the detector
  assign absent_chan.raw   = absent_motor_raw;
  assign absent_chan.limit = absent_cycles;

  // Comparator filter
  // Shares reset with the bank so both qualifiers start low
  // The filtered level stands until a change outlasts the limit
  // A return to the current level before then restarts the count
  persist_filter comp_filter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .chan    (comp_chan.filt)
  );

  // Absent motor filter
  // A long limit means a short loss of the motor signal, such as
  // a stall at low speed, is not reported as a missing motor
  // The confirmed flag is the only absent motor state exported
  persist_filter absent_filter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .chan    (absent_chan.filt)
  );

  // Qualified levels come straight from the filter flops
  // No logic sits between the filter flops and the pins, which
  // keeps the outputs glitch free for downstream fault logic
  // Both levels read low during reset
  assign comparator_filtered    = comp_chan.filtered;
  assign absent_motor_confirmed = absent_chan.filtered;

endmodule : motor_algo_fault_config_regs
`default_nettype wire

// *** logic/motor_cfg_pkg.sv ***
`default_nettype none
package motor_cfg_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned US_PER_S      = 1_000_000;
  localparam int unsigned MS_PER_S      = 1_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / US_PER_S;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int unsigned BLANK_STEP_US = 1;
  localparam int unsigned FILT_STEP_US  = 1;
  localparam int unsigned BLANK_STEP_CYC = BLANK_STEP_US * CYC_PER_US;
  localparam int unsigned FILT_STEP_CYC  = FILT_STEP_US * CYC_PER_US;

  // Register indices; byte address is four times the index
  localparam logic [29:0] TUNE_ONE_IDX  = 30'h9a;
  localparam logic [29:0] TUNE_TWO_IDX  = 30'h9c;
  localparam logic [29:0] FAULT_ONE_IDX = 30'h92;
  localparam logic [29:0] FAULT_TWO_IDX = 30'h94;

  // Storage slots
  localparam logic [1:0] SLOT_TUNE_ONE  = 2'h0;
  localparam logic [1:0] SLOT_TUNE_TWO  = 2'h1;
  localparam logic [1:0] SLOT_FAULT_ONE = 2'h2;
  localparam logic [1:0] SLOT_FAULT_TWO = 2'h3;
  localparam int unsigned NUM_SLOTS     = 4;

  // Values after reset
  localparam logic [31:0] RST_TUNE_ONE  = 32'h00000000;
  localparam logic [31:0] RST_TUNE_TWO  = 32'h00200000;
  localparam logic [31:0] RST_FAULT_ONE = 32'h00000000;
  localparam logic [31:0] RST_FAULT_TWO = 32'h00000000;

  // Field positions and widths
  localparam int unsigned DIV_LSB    = 0;
  localparam int unsigned DIV_W      = 2;
  localparam int unsigned BLANK_LSB  = 27;
  localparam int unsigned BLANK_W    = 4;
  localparam int unsigned FILT_LSB   = 24;
  localparam int unsigned FILT_W     = 3;
  localparam int unsigned ALIGN_LSB  = 18;
  localparam int unsigned ALIGN_W    = 3;
  localparam int unsigned ABSENT_LSB = 27;
  localparam int unsigned ABSENT_W   = 3;

  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  // Startup rate divide factor: one shifted by the code
  function automatic logic [3:0] divide_factor(input logic [1:0] code);
    divide_factor = 4'h1 << code;
  endfunction : divide_factor

  // Alignment duty cap in percent
  function automatic logic [6:0] align_duty_pct(input logic [2:0] code);
    case (code)
      3'h0:    align_duty_pct = 7'h0a;
      3'h1:    align_duty_pct = 7'h0f;
      3'h2:    align_duty_pct = 7'h14;
      3'h3:    align_duty_pct = 7'h19;
      3'h4:    align_duty_pct = 7'h1e;
      3'h5:    align_duty_pct = 7'h28;
      3'h6:    align_duty_pct = 7'h32;
      default: align_duty_pct = 7'h64;
    endcase
  endfunction : align_duty_pct

  // Absent motor deglitch time in milliseconds
  function automatic logic [9:0] absent_motor_ms(input logic [2:0] code);
    case (code)
      3'h0:    absent_motor_ms = 10'h001;
      3'h1:    absent_motor_ms = 10'h00a;
      3'h2:    absent_motor_ms = 10'h019;
      3'h3:    absent_motor_ms = 10'h032;
      3'h4:    absent_motor_ms = 10'h064;
      3'h5:    absent_motor_ms = 10'h0fa;
      3'h6:    absent_motor_ms = 10'h1f4;
      default: absent_motor_ms = 10'h3e8;
    endcase
  endfunction : absent_motor_ms

endpackage : motor_cfg_pkg
`default_nettype wire

// *** logic/persist_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
module persist_filter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Filter channel
  filter_if.filt   chan
);

  logic [31:0] count;          // Cycles of disagreement so far
  logic [31:0] next_count;     // Next disagreement count
  logic        next_filtered;  // Next qualified level

  // A level change passes only once it has outlasted the limit
  always_comb begin
    next_count    = count;
    next_filtered = chan.filtered;
    if (chan.raw == chan.filtered) begin
      // Agreement cancels any partial qualification
      next_count = 32'h00000000;
    end else if (count >= chan.limit) begin
      next_filtered = chan.raw;
      next_count    = 32'h00000000;
    end else begin
      next_count = count + 32'h00000001;
    end
  end

  // Registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count         <= 32'h00000000;
      chan.filtered <= 1'b0;
    end else begin
      count         <= next_count;
      chan.filtered <= next_filtered;
    end
  end

endmodule : persist_filter
`default_nettype wire

// *** verif/motor_cfg_checker_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module motor_cfg_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Steering
  input wire logic        pwm_edge,
  input wire logic        comparator_raw,
  input wire logic        absent_motor_raw,
  input wire logic [3:0]  startup_rate_divider,
  input wire logic [6:0]  align_duty_limit,
  input wire logic        pwm_edge_blank_active,
  input wire logic        comparator_filtered,
  input wire logic        absent_motor_confirmed
);
  // One clock domain for every check
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A read address phase is taken
  wire logic rd_taken = hsel && hready && htrans[1] && !hwrite;
  // High cycles of the blank window since the last edge
  logic [8:0] blank_run;
  logic [8:0] next_blank_run;
  // Restart on each edge; a window longer than code 15 would be a decode slip
  always_comb begin
    next_blank_run = pwm_edge ? 9'h0 : (pwm_edge_blank_active ? blank_run + 9'h1 : 9'h0);
  end
  // Register the run length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) blank_run <= 9'h0;
    else blank_run <= next_blank_run;
  end
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  a_rdata_idle: assert property (!$past(rd_taken) |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_div_legal: assert property ($onehot(startup_rate_divider))
    else $error("divide factor not a power of two");
  a_duty_legal: assert property (align_duty_limit inside {7'h0a, 7'h0f, 7'h14, 7'h19,
    7'h1e, 7'h28, 7'h32, 7'h64}) else $error("duty cap outside table");
  a_blank_start: assert property ($rose(pwm_edge_blank_active) |->
    $past(pwm_edge) ##0 pwm_edge_blank_active [*8]) else $error("blank window without edge");
  a_blank_max: assert property (blank_run <= 9'h12c)
    else $error("blank window too long");
  a_cmp_follow: assert property ($changed(comparator_filtered) |->
    $past(comparator_raw) == comparator_filtered) else $error("comparator output moved alone");
  a_absent_follow: assert property ($changed(absent_motor_confirmed) |->
    $past(absent_motor_raw) == absent_motor_confirmed) else $error("absent flag moved alone");
endmodule : motor_cfg_checker
bind motor_algo_fault_config_regs motor_cfg_checker chk_u (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .pwm_edge, .comparator_raw, .absent_motor_raw,
  .startup_rate_divider, .align_duty_limit, .pwm_edge_blank_active, .comparator_filtered,
  .absent_motor_confirmed);
`default_nettype wire

// *** verif/tb_motor_algo_fault_config_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_motor_algo_fault_config_regs;
  // Stimulus
  logic        hclk, hresetn, hsel, hwrite, pwm_edge, comparator_raw, absent_motor_raw;
  logic [31:0] haddr, hwdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  // Design outputs
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, pwm_edge_blank_active;
  wire logic        comparator_filtered, absent_motor_confirmed;
  wire logic [3:0]  startup_rate_divider;
  wire logic [6:0]  align_duty_limit;
  int fails = 0;
  int checked = 0;
  // Expected decode per code
  logic [6:0] duty_exp [8] = '{7'h0a, 7'h0f, 7'h14, 7'h19, 7'h1e, 7'h28, 7'h32, 7'h64};
  logic [3:0] div_exp [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  // Byte addresses, four times the index
  localparam logic [31:0] A_F1 = 32'h248, A_F2 = 32'h250, A_T1 = 32'h268, A_T2 = 32'h270;

  // One millisecond shortened to 20 cycles
  motor_algo_fault_config_regs #(.MS_CYCLES(32'h14)) dut_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .pwm_edge, .comparator_raw, .absent_motor_raw, .startup_rate_divider, .align_duty_limit,
    .pwm_edge_blank_active, .comparator_filtered, .absent_motor_confirmed);

  // 20 MHz clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Verdict and end of run
  task complete_run;
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Compare and report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Next edge with hready high, bounded
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 16) begin
        fails++;
        complete_run;
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  // One single transfer; entered just after a rising edge
  task xfer(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rdv = hrdata;
  endtask : xfer

  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, motor_cfg_pkg::HSIZE_WORD, d);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, motor_cfg_pkg::HSIZE_WORD, 32'h0);
    chk(rdv, e);
  endtask : rd

  // Pulse one edge and count the high cycles of the window
  task blank(input int exp);
    int n;
    // Let a fresh code reach the decode flop before the edge
    @(posedge hclk) pwm_edge <= 1'b1;
    @(posedge hclk) pwm_edge <= 1'b0;
    n = 0;
    @(negedge hclk);
    while (pwm_edge_blank_active === 1'b1 && n < 400) begin
      n++;
      @(negedge hclk);
    end
    if (n >= 400) begin
      fails++;
      complete_run;
    end
    chk(32'(n), 32'(exp));
    @(posedge hclk);
  endtask : blank

  // Raw level of one filter channel
  task drive(input int sel, input logic v);
    if (sel == 1) absent_motor_raw <= v;
    else comparator_raw <= v;
  endtask : drive

  function automatic logic fout(input int sel);
    return (sel == 1) ? absent_motor_confirmed : comparator_filtered;
  endfunction : fout

  // A short glitch must be dropped, a long level must pass on time
  task filt(input int sel, input int lim);
    int n;
    // Let a fresh limit reach the decode flop first
    @(posedge hclk);
    drive(sel, 1'b1);
    repeat (lim / 2) @(posedge hclk);
    drive(sel, 1'b0);
    repeat (lim + 4) @(posedge hclk);
    chk(32'(fout(sel)), 32'h0);
    drive(sel, 1'b1);
    n = 0;
    while (fout(sel) !== 1'b1 && n < lim + 8) begin
      @(negedge hclk);
      n++;
    end
    if (n >= lim + 8) begin
      fails++;
      complete_run;
    end
    // Level passes at the edge after limit plus one disagreeing samples
    chk(32'(n), 32'(lim + 2));
    @(posedge hclk);
  endtask : filt

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    pwm_edge = 1'b0;
    comparator_raw = 1'b0;
    absent_motor_raw = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(startup_rate_divider), 32'h1);
    chk(32'(align_duty_limit), 32'h0a);
    rd(A_F1, 32'h0);
    rd(A_F2, 32'h0);
    rd(A_T1, 32'h0);
    rd(A_T2, 32'h00200000);
    // Every code row, reserved bit 21 kept set
    for (int i = 0; i < 8; i++) begin
      wr(A_T1, 32'(i % 4));
      wr(A_T2, 32'h00200000 | (32'(i) << 18));
      rd(A_T1, 32'(i % 4));
      rd(A_T2, 32'h00200000 | (32'(i) << 18));
      chk(32'(startup_rate_divider), 32'(div_exp[i % 4]));
      chk(32'(align_duty_limit), 32'(duty_exp[i]));
    end
    // Whole words stored; unmapped and byte writes dropped
    wr(A_F1, 32'hbfffffff);
    wr(A_F2, 32'h5a5a5a5a);
    wr(32'h260, 32'hffffffff);
    xfer(A_F2, 1'b1, 3'h0, 32'h0);
    rd(A_F1, 32'hbfffffff);
    rd(A_F2, 32'h5a5a5a5a);
    rd(32'h260, 32'h0);
    rd(32'h249, 32'h0);
    // Blank code 3 and deglitch code 2: 60 and 40 cycles
    wr(A_T2, 32'h1a200000);
    blank(60);
    filt(0, 40);
    wr(A_T2, 32'h00200000);
    blank(0);
    // Absent code 1 is 10 ms, 200 cycles here
    wr(A_F1, 32'h08000000);
    filt(1, 200);
    // Reset in mid-run restores defaults
    @(posedge hclk) hresetn <= 1'b0;
    @(posedge hclk) hresetn <= 1'b1;
    rd(A_F1, 32'h0);
    rd(A_T2, 32'h00200000);
    chk(32'(startup_rate_divider), 32'h1);
    complete_run;
  end
endmodule : tb_motor_algo_fault_config_regs
`default_nettype wire
